// *** adc_out_pkg.sv ***
package adc_out_pkg;

  localparam int RESULT_W = 12;
  localparam int FRAME_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_CLK_PERIOD_NS = 400;
  localparam int CONV_TIME_NS = 8000;
  // half period of the internal conversion clock, in system clocks
  localparam int CONV_HALF_CYCLES = (CONV_CLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // conversion clock periods per conversion
  localparam int CONV_TICKS = CONV_TIME_NS / CONV_CLK_PERIOD_NS;
  localparam logic [RESULT_W-1:0] BIPOLAR_FLIP = 12'h800;
  localparam logic [3:0] LEAD_ZEROS = 4'h0;
  localparam logic [3:0] HIGH_NIBBLE_PAD = 4'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;

  // three-level format pin, as seen by the digital core
  typedef enum logic [1:0] {
    FMT_PARALLEL = 2'b00,
    FMT_BYTE_GATED = 2'b01,
    FMT_BYTE_FREE = 2'b10
  } format_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STROBE_CONV = 2'b01,
    ST_SELECT_CONV = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic sample_start_strobe_b;
    logic chip_select_b;
    logic read_b;
    logic upper_byte_select;
  } host_ctrl_t;

  typedef struct packed {
    logic serial_bit_clock;
    logic serial_frame_strobe;
    logic serial_result_line;
  } serial_pins_t;

endpackage : adc_out_pkg

// *** conv_clock_gen.sv ***
`timescale 1ns/100ps
module conv_clock_gen #(
  parameter int HALF_CYCLES = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic use_external,
  input wire logic external_conv_clock,
  output logic conv_level,
  output logic conv_rise,
  output logic conv_fall
);
  localparam int CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);

  logic [CNT_W-1:0] div_cnt_q;
  logic int_level_q;
  logic level_q;
  logic level_prev_q;
  logic level_d;

  // internal oscillator stand-in: divider of the system clock
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_cnt_q <= '0;
      int_level_q <= 1'b0;
    end
    else if (div_cnt_q == CNT_LAST)
    begin
      div_cnt_q <= '0;
      int_level_q <= ~int_level_q;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  assign level_d = use_external ? external_conv_clock : int_level_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      level_q <= 1'b0;
      level_prev_q <= 1'b0;
    end
    else
    begin
      level_q <= level_d;
      level_prev_q <= level_q;
    end
  end

  assign conv_level = level_q;
  assign conv_rise = level_q & ~level_prev_q;
  assign conv_fall = ~level_q & level_prev_q;

endmodule : conv_clock_gen

// *** adc_conversion_output_interface.sv ***
`timescale 1ns/100ps
module adc_conversion_output_interface #(
  parameter int CONV_TICK_COUNT = adc_out_pkg::CONV_TICKS,
  parameter int HALF_CYCLES = adc_out_pkg::CONV_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input adc_out_pkg::host_ctrl_t host_ctrl,
  input adc_out_pkg::format_sel_t format_sel,
  input wire logic bipolar_range,
  input wire logic [adc_out_pkg::RESULT_W-1:0] sampled_code,
  input wire logic use_external_clock,
  input wire logic external_conv_clock,
  output logic [adc_out_pkg::RESULT_W-1:0] result_bus_o,
  output logic [adc_out_pkg::RESULT_W-1:0] result_bus_oe,
  output adc_out_pkg::serial_pins_t serial_o,
  output adc_out_pkg::serial_pins_t serial_oe,
  output logic busy_done_b,
  output logic sampler_hold
);
  import adc_out_pkg::*;

  localparam int TICK_W = $clog2(CONV_TICK_COUNT + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CONV_TICK_COUNT);
  localparam int BIT_W = $clog2(FRAME_W + 1);
  localparam logic [BIT_W-1:0] FRAME_BITS = BIT_W'(FRAME_W);

  conv_state_t state_q;
  conv_state_t state_d;
  logic start_prev_q;
  logic cs_prev_q;
  logic selected_q;
  logic strobe_rise;
  logic cs_fall;
  logic selected;
  logic read_start;
  logic start_by_strobe;
  logic start_by_select;
  logic converting;
  logic conv_end;
  logic byte_mode;
  logic conv_level;
  logic conv_rise;
  logic conv_fall;
  logic [TICK_W-1:0] tick_q;
  logic [RESULT_W-1:0] coded_q;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] coded_now;
  logic done_b_q;
  logic select_mode_q;
  logic [FRAME_W-1:0] shift_q;
  logic [BIT_W-1:0] bit_cnt_q;
  logic frame_low_q;
  logic data_q;
  logic sclk_en_q;
  logic sclk_q;
  logic read_ok;
  logic [RESULT_W-1:0] bus_d;
  logic [RESULT_W-1:0] bus_oe_d;

  conv_clock_gen #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_conv_clock (
    .clock(clock),
    .rst_b(rst_b),
    .use_external(use_external_clock),
    .external_conv_clock(external_conv_clock),
    .conv_level(conv_level),
    .conv_rise(conv_rise),
    .conv_fall(conv_fall)
  );

  assign byte_mode = (format_sel == FMT_BYTE_GATED) || (format_sel == FMT_BYTE_FREE);

  // edge detection of the host strobes
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
      selected_q <= 1'b0;
    end
    else
    begin
      start_prev_q <= host_ctrl.sample_start_strobe_b;
      cs_prev_q <= host_ctrl.chip_select_b;
      selected_q <= selected;
    end
  end

  assign strobe_rise = host_ctrl.sample_start_strobe_b & ~start_prev_q;
  assign cs_fall = ~host_ctrl.chip_select_b & cs_prev_q;
  assign selected = ~host_ctrl.chip_select_b & ~host_ctrl.read_b;
  assign read_start = selected & ~selected_q;

  // strobe start is refused while chip select is low
  assign start_by_strobe = (state_q == ST_IDLE) && strobe_rise && host_ctrl.chip_select_b;
  // with the strobe held low, chip select starts; byte select must be low in byte mode
  assign start_by_select = (state_q == ST_IDLE) && cs_fall && !host_ctrl.sample_start_strobe_b
                           && !(byte_mode && host_ctrl.upper_byte_select);
  assign converting = (state_q != ST_IDLE);
  assign conv_end = converting && conv_rise && (tick_q == TICK_LAST);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start_by_strobe)
          state_d = ST_STROBE_CONV;
        else if (start_by_select)
          state_d = ST_SELECT_CONV;
      end
      ST_STROBE_CONV, ST_SELECT_CONV:
      begin
        if (conv_end)
          state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // sampler holds for the whole conversion, tracks otherwise
  assign sampler_hold = converting;

  // conversion length in conversion clock periods
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      tick_q <= '0;
    else if (!converting)
      tick_q <= '0;
    else if (conv_rise && tick_q != TICK_LAST)
      tick_q <= tick_q + 1'b1;
  end

  // output coding chosen by range variant
  assign coded_now = bipolar_range ? (sampled_code ^ BIPOLAR_FLIP) : sampled_code;

  // held sample and the result latch
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      coded_q <= RESULT_RESET;
      result_q <= RESULT_RESET;
    end
    else
    begin
      if (start_by_strobe || start_by_select)
        coded_q <= coded_now;
      if (conv_end)
        result_q <= coded_q;
    end
  end

  // start mode remembered for the status pin
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      select_mode_q <= 1'b0;
    else if (start_by_strobe)
      select_mode_q <= 1'b0;
    else if (start_by_select)
      select_mode_q <= 1'b1;
  end

  // done flag: end of conversion wins over a read in the same cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      done_b_q <= 1'b1;
    else if (conv_end && state_q == ST_STROBE_CONV)
      done_b_q <= 1'b0;
    else if (read_start || start_by_select)
      done_b_q <= 1'b1;
  end

  assign busy_done_b = select_mode_q ? ~converting : done_b_q;

  // serial frame: shifts on conversion clock rise while converting
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q <= '0;
      bit_cnt_q <= '0;
      frame_low_q <= 1'b0;
      data_q <= 1'b1;
    end
    else if (start_by_strobe || start_by_select)
    begin
      shift_q <= {LEAD_ZEROS, coded_now};
      bit_cnt_q <= '0;
      frame_low_q <= 1'b0;
      data_q <= 1'b1;
    end
    else if (converting && conv_rise && byte_mode)
    begin
      if (bit_cnt_q != FRAME_BITS)
      begin
        frame_low_q <= 1'b1;
        data_q <= shift_q[FRAME_W-1];
        shift_q <= {shift_q[FRAME_W-2:0], 1'b0};
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
      else
      begin
        frame_low_q <= 1'b0;
        data_q <= 1'b1;
      end
    end
    else if (!converting)
    begin
      frame_low_q <= 1'b0;
      data_q <= 1'b1;
    end
  end

  // gated serial clock runs from start until the frame is sent
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sclk_en_q <= 1'b0;
    else if (start_by_strobe || start_by_select)
      sclk_en_q <= 1'b1;
    else if (conv_rise && bit_cnt_q == FRAME_BITS)
      sclk_en_q <= 1'b0;
    else if (!converting)
      sclk_en_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sclk_q <= 1'b1;
    else if (format_sel == FMT_BYTE_FREE)
      sclk_q <= conv_level;
    else if (format_sel == FMT_BYTE_GATED && sclk_en_q)
      sclk_q <= conv_level;
    else
      sclk_q <= 1'b1;
  end

  // open drain: value always low, enable pulls the line
  assign serial_o = '0;
  assign serial_oe.serial_bit_clock = byte_mode & ~sclk_q;
  assign serial_oe.serial_frame_strobe = byte_mode & frame_low_q;
  assign serial_oe.serial_result_line = byte_mode & frame_low_q & ~data_q;

  // read path; latches stay off while converting
  assign read_ok = selected && !converting && !start_by_select;

  always_comb
  begin
    bus_d = '0;
    bus_oe_d = '0;
    if (read_ok)
    begin
      if (!byte_mode)
      begin
        bus_d = result_q;
        bus_oe_d = '1;
      end
      else if (host_ctrl.upper_byte_select)
      begin
        bus_d[BYTE_W-1:0] = {HIGH_NIBBLE_PAD, result_q[RESULT_W-1:BYTE_W]};
        bus_oe_d[BYTE_W-1:0] = '1;
      end
      else
      begin
        bus_d[BYTE_W-1:0] = result_q[BYTE_W-1:0];
        bus_oe_d[BYTE_W-1:0] = '1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result_bus_o <= '0;
      result_bus_oe <= '0;
    end
    else
    begin
      result_bus_o <= bus_d;
      result_bus_oe <= bus_oe_d;
    end
  end

  logic unused_fall;
  assign unused_fall = conv_fall;

endmodule : adc_conversion_output_interface

// *** adc_out_checker.sv ***
`timescale 1ns/100ps
module adc_out_checker #(
  parameter int CONV_TICK_COUNT = 20,
  parameter int HALF_CYCLES = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input adc_out_pkg::host_ctrl_t host_ctrl,
  input adc_out_pkg::format_sel_t format_sel,
  input wire logic [adc_out_pkg::RESULT_W-1:0] result_bus_o,
  input wire logic [adc_out_pkg::RESULT_W-1:0] result_bus_oe,
  input adc_out_pkg::serial_pins_t serial_o,
  input adc_out_pkg::serial_pins_t serial_oe,
  input wire logic busy_done_b,
  input wire logic sampler_hold
);
  import adc_out_pkg::*;
  localparam int FS_MAX = 2 * HALF_CYCLES + 4;
  wire logic byte_f = format_sel inside {FMT_BYTE_GATED, FMT_BYTE_FREE};
  wire logic rd_on = |result_bus_oe;
  wire logic strb = host_ctrl.sample_start_strobe_b;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_oe_read;
    rd_on |-> $past(!host_ctrl.chip_select_b && !host_ctrl.read_b);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("bus driven without read");
  property p_no_conv_read;
    sampler_hold |-> result_bus_oe == 12'h000;
  endproperty
  a_no_conv_read: assert property (p_no_conv_read) else $error("bus driven in conversion");
  property p_par_width;
    rd_on && format_sel == FMT_PARALLEL |-> result_bus_oe == 12'hFFF;
  endproperty
  a_par_width: assert property (p_par_width) else $error("parallel width");
  property p_byte_width;
    rd_on && byte_f |-> result_bus_oe == 12'h0FF;
  endproperty
  a_byte_width: assert property (p_byte_width) else $error("byte width");
  property p_nibble;
    rd_on && byte_f && $past(host_ctrl.upper_byte_select) |-> result_bus_o[7:4] == 4'h0;
  endproperty
  a_nibble: assert property (p_nibble) else $error("upper nibble not zero");
  property p_no_serial;
    format_sel == FMT_PARALLEL [*3] |-> serial_oe == 3'h0;
  endproperty
  a_no_serial: assert property (p_no_serial) else $error("serial in parallel");
  property p_open_drain;
    serial_o == 3'h0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("serial driven high");
  property p_strobe_start;
    $rose(strb) && host_ctrl.chip_select_b && !sampler_hold |=> sampler_hold;
  endproperty
  a_strobe_start: assert property (p_strobe_start) else $error("no strobe start");
  property p_sel_start;
    $fell(host_ctrl.chip_select_b) && !strb && !sampler_hold && !(byte_f && host_ctrl.upper_byte_select)
      |=> sampler_hold && !busy_done_b;
  endproperty
  a_sel_start: assert property (p_sel_start) else $error("no select start");
  property p_done;
    $fell(sampler_hold) && strb |-> !busy_done_b;
  endproperty
  a_done: assert property (p_done) else $error("done flag missing");
  property p_done_clr;
    $fell(host_ctrl.read_b) && !host_ctrl.chip_select_b && !sampler_hold && strb |=> busy_done_b;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");
  property p_busy_end;
    $fell(sampler_hold) && !strb |-> busy_done_b;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");
  property p_frame;
    $rose(sampler_hold) && byte_f |-> ##[0:FS_MAX] serial_oe.serial_frame_strobe;
  endproperty
  a_frame: assert property (p_frame) else $error("frame strobe late");
  c_strobe: cover property ($rose(sampler_hold) && strb);
  c_select: cover property ($rose(sampler_hold) && !strb);
  c_frame: cover property ($fell(serial_oe.serial_frame_strobe));
endmodule : adc_out_checker

bind adc_conversion_output_interface adc_out_checker #(
  .CONV_TICK_COUNT(CONV_TICK_COUNT),
  .HALF_CYCLES(HALF_CYCLES)
) chk_u (
  .clock(clock), .rst_b(rst_b), .host_ctrl(host_ctrl), .format_sel(format_sel),
  .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe), .serial_o(serial_o),
  .serial_oe(serial_oe), .busy_done_b(busy_done_b), .sampler_hold(sampler_hold)
);

// *** adc_host_model.sv ***
`timescale 1ns/100ps
module adc_host_model (
  input wire logic sclk_w,
  input wire logic strobe_w,
  input wire logic data_w,
  output logic [15:0] frame_q,
  output logic [4:0] bits_q
);
  initial
  begin
    frame_q = 16'h0000;
    bits_q = 5'h00;
  end
  always @(negedge strobe_w) bits_q = 5'h00;
  // sample on falling clock while framed
  always @(negedge sclk_w)
  begin
    if (!strobe_w)
    begin
      frame_q = {frame_q[14:0], data_w};
      bits_q = bits_q + 5'h01;
    end
  end
endmodule : adc_host_model

// *** testbench.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module testbench;
  import adc_out_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  host_ctrl_t host_ctrl = 4'hE;
  format_sel_t format_sel = FMT_PARALLEL;
  logic bipolar_range = 1'b0;
  logic [11:0] sampled_code = 12'h000;
  logic use_external_clock = 1'b0;
  logic external_conv_clock = 1'b0;
  logic [11:0] result_bus_o, result_bus_oe;
  serial_pins_t serial_o, serial_oe, lvl;
  logic busy_done_b, sampler_hold;
  logic [15:0] frame_q;
  logic [4:0] bits_q;
  logic [11:0] corner [4] = '{12'h000, 12'hFFF, 12'h7FF, 12'h800};
  int failures = 0;
  int n_tests = 0;
  int edges = 0;
  localparam int INT_HALF = 2;
  localparam int EXT_HALF = 3;
  always #12.5 clock = ~clock;
  // external conversion clock slower than the internal one, so the source is visible
  always #(EXT_HALF * CLK_PERIOD_NS) external_conv_clock = ~external_conv_clock;
  assign lvl = ~serial_oe | serial_o;
  always @(lvl.serial_bit_clock) edges++;
  adc_conversion_output_interface #(.CONV_TICK_COUNT(17), .HALF_CYCLES(INT_HALF)) dut_u (
    .clock(clock), .rst_b(rst_b), .host_ctrl(host_ctrl), .format_sel(format_sel),
    .bipolar_range(bipolar_range), .sampled_code(sampled_code), .use_external_clock(use_external_clock),
    .external_conv_clock(external_conv_clock), .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe),
    .serial_o(serial_o), .serial_oe(serial_oe), .busy_done_b(busy_done_b), .sampler_hold(sampler_hold)
  );
  adc_host_model host_u (
    .sclk_w(lvl.serial_bit_clock), .strobe_w(lvl.serial_frame_strobe), .data_w(lvl.serial_result_line),
    .frame_q(frame_q), .bits_q(bits_q)
  );
  function automatic logic [11:0] exp_code(input logic bip, input logic [11:0] c);
    return c ^ {bip, 11'h000};
  endfunction : exp_code
  task automatic give_verdict;
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic rd_chk(input logic ubs, input logic [11:0] e);
    host_ctrl = {host_ctrl.sample_start_strobe_b, 2'b00, ubs};
    repeat (2) @(negedge clock);
    if (format_sel == FMT_PARALLEL)
    begin
      `CHK(result_bus_o, e)
      `CHK(result_bus_oe, 12'hFFF)
    end
    else
    begin
      `CHK(result_bus_o[7:0], ubs ? {4'h0, e[11:8]} : e[7:0])
      `CHK(result_bus_oe, 12'h0FF)
    end
    host_ctrl = {host_ctrl.sample_start_strobe_b, 3'b110};
    repeat (2) @(negedge clock);
    `CHK(result_bus_oe, 12'h000)
  endtask : rd_chk
  task automatic conv(input format_sel_t f, input logic sel, input logic [11:0] c);
    logic [11:0] e;
    int k;
    e = exp_code(bipolar_range, c);
    format_sel = f;
    sampled_code = c;
    host_ctrl = 4'h6;
    @(negedge clock);
    host_ctrl = sel ? 4'h0 : 4'hE;
    @(negedge clock);
    `CHK(sampler_hold, 1'b1)
    `CHK(result_bus_oe, 12'h000)
    // later input changes must not reach the result
    sampled_code = ~c;
    if (!sel)
    begin
      // a second strobe rise mid-conversion is ignored
      host_ctrl = 4'h6;
      @(negedge clock);
      host_ctrl = 4'hE;
    end
    for (k = 0; k < 400 && sampler_hold !== 1'b0; k++) @(negedge clock);
    if (k == 400)
    begin
      failures++;
      give_verdict();
    end
    `CHK(busy_done_b, sel)
    rd_chk(1'b0, e);
    `CHK(busy_done_b, 1'b1)
    if (f != FMT_PARALLEL)
    begin
      rd_chk(1'b1, e);
      `CHK(bits_q, 5'h10)
      `CHK(frame_q, {4'h0, e})
    end
    k = edges;
    repeat (24) @(negedge clock);
    `CHK(edges - k, (f != FMT_BYTE_FREE) ? 0 : 24 / (use_external_clock ? EXT_HALF : INT_HALF))
  endtask : conv
  initial
  begin
    void'($urandom(32'hD8D39384));
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    `CHK({busy_done_b, sampler_hold, result_bus_oe}, 14'h2000)
    for (int i = 0; i < 24; i++)
    begin
      bipolar_range = (i < 4) | 1'($urandom);
      use_external_clock = 1'($urandom);
      conv(format_sel_t'(i % 3), 1'((i / 3) % 2), (i < 4) ? corner[i] : 12'($urandom));
    end
    give_verdict();
  end
endmodule : testbench
